/* File: rtl/brk_fail_pkg.sv */
// constants, register map and types of the breaker-failure timing block
package brk_fail_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int PROG_CYCLE_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * PROG_CYCLE_US;
  localparam int DELAY_STEP_MS = 5;
  localparam int RETRIP_DFLT_MS = 100;
  localparam int CBF_DFLT_MS = 200;
  localparam logic [18:0] RETRIP_DFLT_STEPS = 19'(RETRIP_DFLT_MS / DELAY_STEP_MS);
  localparam logic [18:0] CBF_DFLT_STEPS = 19'(CBF_DFLT_MS / DELAY_STEP_MS);
  localparam logic [21:0] STEP_MS = 22'(DELAY_STEP_MS);
  localparam logic [21:0] CNT_MAX = 22'h3f_ffff;
  localparam int EV_DEPTH = 16;
  localparam int REC_DEPTH = 12;
  localparam logic [15:0] EV_SEL_DFLT = 16'hffff;
  localparam logic [2:0] GROUP_DFLT = 3'h0;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RETRIP_DLY = 8'h04;
  localparam logic [7:0] OFS_CBF_DLY = 8'h08;
  localparam logic [7:0] OFS_EV_SEL = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_TIME_MS = 8'h14;
  localparam logic [7:0] OFS_CNT_A = 8'h18;
  localparam logic [7:0] OFS_CNT_B = 8'h1c;
  localparam logic [7:0] OFS_CNT_CLR = 8'h20;
  localparam logic [7:0] OFS_EV_IDX = 8'h28;
  localparam logic [7:0] OFS_EV_TS = 8'h2c;
  localparam logic [7:0] OFS_EV_CODE = 8'h30;
  localparam logic [7:0] OFS_REC_IDX = 8'h34;
  localparam logic [7:0] OFS_REC_TS = 8'h38;
  localparam logic [7:0] OFS_REC_INFO = 8'h3c;
  localparam logic [7:0] OFS_REC_CUR = 8'h40;
  localparam logic [7:0] OFS_REC_TTR = 8'h44;
  localparam logic [7:0] OFS_REC_TTC = 8'h48;
  // event sources, also status bit positions
  localparam int SRC_START = 0;
  localparam int SRC_RETRIP = 1;
  localparam int SRC_CBF = 2;
  localparam int SRC_BLOCK = 3;
  localparam int SRC_MONITOR = 4;
  localparam int SRC_SIGNAL = 5;
  localparam int SRC_PHASE = 6;
  localparam int SRC_RES = 7;
  typedef enum logic [1:0] {CRIT_CURRENT, CRIT_CUR_AND_OUT, CRIT_CUR_OR_OUT, CRIT_INPUT} crit_t;
  typedef struct packed {
    logic [31:0] ts;
    logic [2:0] src;
    logic on;
  } ev_t;
  typedef struct packed {
    logic [31:0] ts;
    logic [2:0] src;
    logic [2:0] group;
    logic [15:0] max_phase;
    logic [15:0] residual;
    logic [21:0] to_retrip;
    logic [21:0] to_cbf;
  } rec_t;
endpackage

/* File: rtl/ring_ifs.sv */
// carriers between the timing logic and its two ring logs
`timescale 1ns/1ps
interface ev_if;
  import brk_fail_pkg::*;
  logic wr;
  ev_t wdata;
  logic [3:0] rd_idx;
  ev_t rdata;
  logic [4:0] fill;
  modport writer(output wr, output wdata, output rd_idx, input rdata, input fill);
  modport ring(input wr, input wdata, input rd_idx, output rdata, output fill);
endinterface

interface rec_if;
  import brk_fail_pkg::*;
  logic wr;
  rec_t wdata;
  logic [3:0] rd_idx;
  rec_t rdata;
  logic [4:0] fill;
  modport writer(output wr, output wdata, output rd_idx, input rdata, input fill);
  modport ring(input wr, input wdata, input rd_idx, output rdata, output fill);
endinterface

/* File: rtl/event_ring.sv */
// circular store of filtered time-stamped events, index 0 is the newest
`timescale 1ns/1ps
module event_ring (
  input wire logic hclk,
  input wire logic hresetn,
  ev_if.ring port_if
);
  import brk_fail_pkg::*;
  typedef struct packed {
    ev_t [EV_DEPTH-1:0] mem;
    logic [3:0] wp;
    logic [4:0] fill;
  } ev_ring_state_t;
  ev_ring_state_t s_r;
  ev_ring_state_t s_nxt;
  logic [3:0] slot;

  always_comb begin
    s_nxt = s_r;
    if (port_if.wr) begin
      s_nxt.mem[s_r.wp] = port_if.wdata;
      s_nxt.wp = s_r.wp + 4'h1;
      if (s_r.fill != 5'(EV_DEPTH)) begin
        s_nxt.fill = s_r.fill + 5'h1;
      end
    end
  end

  // depth is a power of two, so the pointer wraps by itself
  assign slot = s_r.wp - 4'h1 - port_if.rd_idx;
  assign port_if.rdata = ({1'b0, port_if.rd_idx} < s_r.fill) ? s_r.mem[slot] : '0;
  assign port_if.fill = s_r.fill;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* File: rtl/record_ring.sv */
// twelve-deep operation record log, newest overwrites oldest
`timescale 1ns/1ps
module record_ring (
  input wire logic hclk,
  input wire logic hresetn,
  rec_if.ring port_if
);
  import brk_fail_pkg::*;
  typedef struct packed {
    rec_t [REC_DEPTH-1:0] mem;
    logic [3:0] wp;
    logic [4:0] fill;
  } rec_ring_state_t;
  rec_ring_state_t s_r;
  rec_ring_state_t s_nxt;
  logic [4:0] slot;

  always_comb begin
    s_nxt = s_r;
    if (port_if.wr) begin
      s_nxt.mem[s_r.wp] = port_if.wdata;
      s_nxt.wp = (s_r.wp == 4'(REC_DEPTH - 1)) ? 4'h0 : s_r.wp + 4'h1;
      if (s_r.fill != 5'(REC_DEPTH)) begin
        s_nxt.fill = s_r.fill + 5'h1;
      end
    end
  end

  // depth is not a power of two: wrap the read slot by hand
  always_comb begin
    slot = 5'(REC_DEPTH) + {1'b0, s_r.wp} - 5'h1 - {1'b0, port_if.rd_idx};
    if (slot >= 5'(REC_DEPTH)) begin
      slot = slot - 5'(REC_DEPTH);
    end
  end
  assign port_if.rdata = ({1'b0, port_if.rd_idx} < s_r.fill) ? s_r.mem[slot[3:0]] : '0;
  assign port_if.fill = s_r.fill;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* File: rtl/breaker_failure_timing_logic.sv */
// breaker-failure supervision: criteria, delay timing, events, counters, records, bus slave
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
// Operation
// - current criterion starts on phase or residual
// - current criterion trips after delay while over
// - current criterion clears when both currents drop
// - and-criterion halts counter until primary trip
// - and-criterion counts with trip and current
// - and-criterion resets on current or trip drop
// - or-criterion counts on current or trip
// - or-criterion trips if either holds whole delay
// - or-criterion resets only when both inactive
// - input criterion counts and trips on input
// - separate on and off events per status
// - per-source selection of on, off, both
// - every stored event carries a time stamp
// - clearable retrip, failure, start, blocked counters
// - twelve newest records, oldest overwritten
// - record captured on start, retrip, failure, blocked on events
// - record holds time, event, currents, remaining, group
// - blocking raises blocked, releases running start
// - one pick-up drives retrip and failure timers
// - delays in 5 ms steps, defaults 100/200 ms
module breaker_failure_timing_logic #(
  parameter int TICK_CYCLES_P = brk_fail_pkg::TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic phase_over,
  input wire logic residual_over,
  input wire logic primary_trip,
  input wire logic digital_in,
  input wire logic block_in,
  input wire logic [15:0] max_phase_current,
  input wire logic [15:0] residual_current,
  output logic start_output,
  output logic retrip_output,
  output logic breaker_failure_output,
  output logic blocked_output
);
  import brk_fail_pkg::*;

  typedef struct packed {
    logic [1:0] crit;
    logic retrip_en;
    logic [2:0] group;
    logic [18:0] retrip_steps;
    logic [18:0] cbf_steps;
    logic [15:0] ev_sel;
    logic [31:0] tick_cnt;
    logic [31:0] ts_ms;
    logic [21:0] cnt_ms;
    logic [7:0] status;
    logic [7:0] prev;
    logic [7:0] pend_on;
    logic [7:0] pend_off;
    logic [15:0] cnt_retrip;
    logic [15:0] cnt_cbf;
    logic [15:0] cnt_start;
    logic [15:0] cnt_blocked;
    logic [3:0] ev_idx;
    logic [3:0] rec_idx;
    logic dp_wr;
    logic dp_rd;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;
  ev_if ev_bus();
  rec_if rec_bus();

  function automatic logic [21:0] delay_ms(input logic [18:0] steps);
    delay_ms = 22'(steps) * STEP_MS;
  endfunction

  function automatic logic [21:0] remaining(input logic [18:0] steps, input logic [21:0] cnt);
    logic [21:0] lim;
    lim = delay_ms(steps);
    remaining = (cnt >= lim) ? 22'h0 : lim - cnt;
  endfunction

  function automatic logic [15:0] bump(input logic [15:0] c, input logic hit, input logic clr);
    // an occurrence in the clearing cycle survives as a count of one
    if (clr) begin
      bump = hit ? 16'h0001 : 16'h0000;
    end else if (hit && c != 16'hffff) begin
      bump = c + 16'h0001;
    end else begin
      bump = c;
    end
  endfunction

  logic tick;
  logic cur_over;
  logic run;
  logic timing;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] pend_any;
  logic [2:0] src;
  logic found;
  logic serve_on;
  logic [3:0] clr;
  logic acc;

  always_comb begin
    s_nxt = s_r;
    tick = 1'b0;
    cur_over = 1'b0;
    run = 1'b0;
    timing = 1'b0;
    rise = 8'h00;
    fall = 8'h00;
    pend_any = 8'h00;
    src = 3'h0;
    found = 1'b0;
    serve_on = 1'b0;
    clr = 4'h0;
    acc = 1'b0;
    ev_bus.wr = 1'b0;
    ev_bus.wdata = '0;
    rec_bus.wr = 1'b0;
    rec_bus.wdata = '0;

    // program-cycle tick and millisecond time base
    tick = (s_r.tick_cnt >= 32'(TICK_CYCLES_P - 1));
    s_nxt.tick_cnt = tick ? 32'h0 : s_r.tick_cnt + 32'h1;
    if (tick) begin
      s_nxt.ts_ms = s_r.ts_ms + 32'h1;
    end

    // start criterion selects the running condition
    cur_over = phase_over | residual_over;
    case (crit_t'(s_r.crit))
      CRIT_CURRENT: begin
        run = cur_over;
      end
      CRIT_CUR_AND_OUT: begin
        // over current without trip holds the count at zero
        run = cur_over & primary_trip;
      end
      CRIT_CUR_OR_OUT: begin
        run = cur_over | primary_trip;
      end
      CRIT_INPUT: begin
        run = digital_in;
      end
      default: begin
        run = 1'b0;
      end
    endcase

    // blocking stops timing and releases a start in progress
    timing = run & ~block_in;
    if (!timing) begin
      s_nxt.cnt_ms = 22'h0;
    end else if (tick && s_r.cnt_ms != CNT_MAX) begin
      s_nxt.cnt_ms = s_r.cnt_ms + 22'h1;
    end

    // one shared counter serves both delays
    s_nxt.status[SRC_START] = timing;
    s_nxt.status[SRC_RETRIP] = timing & s_r.retrip_en
      & (s_nxt.cnt_ms >= delay_ms(s_r.retrip_steps));
    s_nxt.status[SRC_CBF] = timing
      & (s_nxt.cnt_ms >= delay_ms(s_r.cbf_steps));
    s_nxt.status[SRC_BLOCK] = run & block_in;
    s_nxt.status[SRC_MONITOR] = primary_trip;
    s_nxt.status[SRC_SIGNAL] = digital_in;
    s_nxt.status[SRC_PHASE] = phase_over;
    s_nxt.status[SRC_RES] = residual_over;

    // edge detection feeds pending on and off events
    s_nxt.prev = s_r.status;
    rise = s_r.status & ~s_r.prev;
    fall = ~s_r.status & s_r.prev;
    pend_any = s_r.pend_on | s_r.pend_off;
    for (int i = 7; i >= 0; i--) begin
      if (pend_any[i]) begin
        src = 3'(i);
        found = 1'b1;
      end
    end
    serve_on = found & s_r.pend_on[src];
    if (found) begin
      if (serve_on) begin
        s_nxt.pend_on[src] = 1'b0;
      end else begin
        s_nxt.pend_off[src] = 1'b0;
      end
      // filter picks which directions reach the event store
      ev_bus.wr = serve_on ? s_r.ev_sel[2*src] : s_r.ev_sel[2*src+1];
      ev_bus.wdata.ts = s_r.ts_ms;
      ev_bus.wdata.src = src;
      ev_bus.wdata.on = serve_on;
      rec_bus.wr = serve_on && (src <= 3'(SRC_BLOCK));
      rec_bus.wdata.ts = s_r.ts_ms;
      rec_bus.wdata.src = src;
      rec_bus.wdata.group = s_r.group;
      rec_bus.wdata.max_phase = max_phase_current;
      rec_bus.wdata.residual = residual_current;
      rec_bus.wdata.to_retrip = remaining(s_r.retrip_steps, s_r.cnt_ms);
      rec_bus.wdata.to_cbf = remaining(s_r.cbf_steps, s_r.cnt_ms);
    end
    // a new edge wins over the service that drops its bit
    s_nxt.pend_on = s_nxt.pend_on | rise;
    s_nxt.pend_off = s_nxt.pend_off | fall;

    // bus write data phase
    if (s_r.dp_wr) begin
      case (s_r.dp_addr)
        OFS_CTRL: begin
          s_nxt.crit = hwdata[1:0];
          s_nxt.retrip_en = hwdata[2];
          s_nxt.group = hwdata[6:4];
        end
        OFS_RETRIP_DLY: begin
          s_nxt.retrip_steps = hwdata[18:0];
        end
        OFS_CBF_DLY: begin
          s_nxt.cbf_steps = hwdata[18:0];
        end
        OFS_EV_SEL: begin
          s_nxt.ev_sel = hwdata[15:0];
        end
        OFS_TIME_MS: begin
          s_nxt.ts_ms = hwdata; // software setting wins over the tick
        end
        OFS_CNT_CLR: begin
          clr = hwdata[3:0];
        end
        OFS_EV_IDX: begin
          s_nxt.ev_idx = hwdata[3:0];
        end
        OFS_REC_IDX: begin
          s_nxt.rec_idx = hwdata[3:0];
        end
        default: begin
        end
      endcase
    end

    s_nxt.cnt_retrip = bump(s_r.cnt_retrip, rise[SRC_RETRIP], clr[0]);
    s_nxt.cnt_cbf = bump(s_r.cnt_cbf, rise[SRC_CBF], clr[1]);
    s_nxt.cnt_start = bump(s_r.cnt_start, rise[SRC_START], clr[2]);
    s_nxt.cnt_blocked = bump(s_r.cnt_blocked, rise[SRC_BLOCK], clr[3]);

    // reads take one wait state so a just-written index is seen
    acc = hsel & hready & htrans[1];
    s_nxt.dp_wr = acc & hwrite;
    s_nxt.dp_rd = acc & ~hwrite;
    if (acc) begin
      s_nxt.dp_addr = haddr[7:0];
    end
    if (acc && !hwrite) begin
      s_nxt.ready = 1'b0;
    end
    if (s_r.dp_rd) begin
      s_nxt.ready = 1'b1;
      case (s_r.dp_addr)
        OFS_CTRL: s_nxt.rdata = {25'h0, s_r.group, 1'b0, s_r.retrip_en, s_r.crit};
        OFS_RETRIP_DLY: s_nxt.rdata = {13'h0, s_r.retrip_steps};
        OFS_CBF_DLY: s_nxt.rdata = {13'h0, s_r.cbf_steps};
        OFS_EV_SEL: s_nxt.rdata = {16'h0, s_r.ev_sel};
        OFS_STATUS: s_nxt.rdata = {2'h0, s_r.cnt_ms, s_r.status};
        OFS_TIME_MS: s_nxt.rdata = s_r.ts_ms;
        OFS_CNT_A: s_nxt.rdata = {s_r.cnt_cbf, s_r.cnt_retrip};
        OFS_CNT_B: s_nxt.rdata = {s_r.cnt_blocked, s_r.cnt_start};
        OFS_EV_IDX: s_nxt.rdata = {28'h0, s_r.ev_idx};
        OFS_EV_TS: s_nxt.rdata = ev_bus.rdata.ts;
        OFS_EV_CODE: begin
          s_nxt.rdata = {19'h0, ev_bus.fill, 4'h0, ev_bus.rdata.src, ev_bus.rdata.on};
        end
        OFS_REC_IDX: s_nxt.rdata = {23'h0, rec_bus.fill, s_r.rec_idx};
        OFS_REC_TS: s_nxt.rdata = rec_bus.rdata.ts;
        OFS_REC_INFO: s_nxt.rdata = {25'h0, rec_bus.rdata.group, 1'b0, rec_bus.rdata.src};
        OFS_REC_CUR: s_nxt.rdata = {rec_bus.rdata.max_phase, rec_bus.rdata.residual};
        OFS_REC_TTR: s_nxt.rdata = {10'h0, rec_bus.rdata.to_retrip};
        OFS_REC_TTC: s_nxt.rdata = {10'h0, rec_bus.rdata.to_cbf};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    s_nxt.resp = 1'b0;
  end

  assign ev_bus.rd_idx = s_r.ev_idx;
  assign rec_bus.rd_idx = s_r.rec_idx;

  event_ring u_event_ring (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_if(ev_bus.ring)
  );

  record_ring u_record_ring (
    .hclk(hclk),
    .hresetn(hresetn),
    .port_if(rec_bus.ring)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.crit <= CRIT_CURRENT;
      s_r.retrip_en <= 1'b1;
      s_r.group <= GROUP_DFLT;
      s_r.retrip_steps <= RETRIP_DFLT_STEPS;
      s_r.cbf_steps <= CBF_DFLT_STEPS;
      s_r.ev_sel <= EV_SEL_DFLT;
      s_r.ready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.ready;
  assign hresp = s_r.resp;
  assign start_output = s_r.status[SRC_START];
  assign retrip_output = s_r.status[SRC_RETRIP];
  assign breaker_failure_output = s_r.status[SRC_CBF];
  assign blocked_output = s_r.status[SRC_BLOCK];
endmodule

/* File: sim/bf_assertions.sv */
// pin-level checks of the breaker-failure block
`timescale 1ns/1ps
module bf_assertions #(
  parameter int TICK_CYCLES_P = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic phase_over,
  input wire logic residual_over,
  input wire logic primary_trip,
  input wire logic digital_in,
  input wire logic block_in,
  input wire logic [15:0] max_phase_current,
  input wire logic [15:0] residual_current,
  input wire logic start_output,
  input wire logic retrip_output,
  input wire logic breaker_failure_output,
  input wire logic blocked_output
);
  import brk_fail_pkg::*;
  logic [1:0] crit_r;
  logic [18:0] steps_r;
  logic [7:0] wa_r;
  logic wv_r, rd_r, run;
  int cnt_r, lo, hi;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_comb begin
    case (crit_r)
      2'h0: run = phase_over || residual_over;
      2'h1: run = (phase_over || residual_over) && primary_trip;
      2'h2: run = phase_over || residual_over || primary_trip;
      default: run = digital_in;
    endcase
    // tick phase is unknown to us, so the window is one tick wide plus slack
    lo = (int'(steps_r) * DELAY_STEP_MS - 1) * TICK_CYCLES_P - 2;
    hi = int'(steps_r) * DELAY_STEP_MS * TICK_CYCLES_P + 3;
  end
  // criterion and failure delay mirrored from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crit_r <= 2'h0;
      steps_r <= CBF_DFLT_STEPS;
      wa_r <= 8'h00;
      wv_r <= 1'b0;
      rd_r <= 1'b0;
      cnt_r <= 0;
    end else begin
      wv_r <= hsel && hready && htrans[1] && hwrite;
      rd_r <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) wa_r <= haddr[7:0];
      if (wv_r && hready && wa_r == OFS_CTRL) crit_r <= hwdata[1:0];
      if (wv_r && hready && wa_r == OFS_CBF_DLY) steps_r <= hwdata[18:0];
      cnt_r <= (run && !block_in) ? cnt_r + 1 : 0;
    end
  end
  a_start_follows: assert property (
    run && !block_in |=> start_output) else $error("start missing while criterion holds");
  a_idle_clears: assert property (
    !run |=> !(start_output || retrip_output || breaker_failure_output))
    else $error("outputs stand without a running criterion");
  a_fail_sticks: assert property (
    breaker_failure_output && run && !block_in |=> breaker_failure_output)
    else $error("failure output dropped while criterion holds");
  a_fail_early: assert property (
    $rose(breaker_failure_output) |-> cnt_r >= lo) else $error("failure output too early");
  a_fail_late: assert property (
    cnt_r == hi |-> breaker_failure_output) else $error("failure output too late");
  a_block_wins: assert property (
    run && block_in |=> blocked_output && !start_output && !breaker_failure_output)
    else $error("blocking did not take over");
  a_outputs_gated: assert property (
    retrip_output || breaker_failure_output |-> start_output)
    else $error("timer output without start");
  a_read_wait: assert property (
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_rdata_hold: assert property (
    !$stable(hrdata) |-> $past(rd_r)) else $error("read data changed outside a read");
  a_resp_okay: assert property (
    !hresp) else $error("slave answered with an error response");
endmodule

bind breaker_failure_timing_logic bf_assertions #(.TICK_CYCLES_P(TICK_CYCLES_P)) i_bf_assertions (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .phase_over(phase_over),
  .residual_over(residual_over), .primary_trip(primary_trip), .digital_in(digital_in),
  .block_in(block_in), .max_phase_current(max_phase_current),
  .residual_current(residual_current), .start_output(start_output),
  .retrip_output(retrip_output), .breaker_failure_output(breaker_failure_output),
  .blocked_output(blocked_output));

/* File: sim/breaker_model.sv */
// far-side breaker: trip coils open it unless stuck, upstream trips are latched
`timescale 1ns/1ps
module breaker_model #(
  parameter int OPEN_CYCLES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic fault_phase,
  input wire logic fault_res,
  input wire logic stuck,
  input wire logic trip_coil,
  input wire logic retrip_coil,
  input wire logic upstream_coil,
  output logic phase_over,
  output logic residual_over,
  output logic upstream_open
);
  int coil_cnt;
  logic open_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coil_cnt <= 0;
      open_r <= 1'b0;
      upstream_open <= 1'b0;
    end else begin
      coil_cnt <= ((trip_coil || retrip_coil) && !stuck) ? coil_cnt + 1 : 0;
      // breaker recloses only once the fault is gone
      if (coil_cnt >= OPEN_CYCLES) open_r <= 1'b1;
      else if (!fault_phase && !fault_res) open_r <= 1'b0;
      if (upstream_coil) upstream_open <= 1'b1;
      else if (!fault_phase && !fault_res) upstream_open <= 1'b0;
    end
  end
  assign phase_over = fault_phase && !open_r;
  assign residual_over = fault_res && !open_r;
endmodule

/* File: sim/tb_breaker_failure_timing_logic.sv */
// bench: criterion table, counters, logs, blocking and a clearing breaker
`timescale 1ns/1ps
module tb_breaker_failure_timing_logic;
  import brk_fail_pkg::*;
  typedef struct {string name; logic [31:0] val; logic [31:0] mask;} note_t;
  note_t notes[$];
  note_t nt;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_dp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic phase_over, residual_over, primary_trip, digital_in, block_in;
  logic start_output, retrip_output, breaker_failure_output, blocked_output;
  logic fault_phase, fault_res, stuck, upstream_open, run, prev;
  logic [15:0] max_phase_current, residual_current;
  // per criterion: {phase, residual, trip, input} steps and whether each runs
  logic [3:0] vec [4][4] = '{'{4'h2, 4'h4, 4'h8, 4'h0}, '{4'h8, 4'ha, 4'h8, 4'h0},
    '{4'h0, 4'h2, 4'h4, 4'h0}, '{4'ha, 4'h1, 4'h9, 4'h0}};
  logic [3:0] runs [4] = '{4'h6, 4'h2, 4'h6, 4'h6};
  int fails, checks_done, seed;
  assign hready = hreadyout;
  breaker_failure_timing_logic #(.TICK_CYCLES_P(4)) i_breaker_failure_timing_logic (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .phase_over(phase_over),
    .residual_over(residual_over), .primary_trip(primary_trip), .digital_in(digital_in),
    .block_in(block_in), .max_phase_current(max_phase_current),
    .residual_current(residual_current), .start_output(start_output),
    .retrip_output(retrip_output), .breaker_failure_output(breaker_failure_output),
    .blocked_output(blocked_output));
  breaker_model i_breaker_model (.hclk(hclk), .hresetn(hresetn), .fault_phase(fault_phase),
    .fault_res(fault_res), .stuck(stuck), .trip_coil(primary_trip),
    .retrip_coil(retrip_output), .upstream_coil(breaker_failure_output),
    .phase_over(phase_over), .residual_over(residual_over), .upstream_open(upstream_open));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      fails++;
      summarize();
    end
  endtask
  task automatic bus(logic wr, logic [7:0] a, logic [31:0] d);
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
  endtask
  task automatic rd(string name, logic [7:0] a, logic [31:0] v, logic [31:0] m = '1);
    notes.push_back('{name, v, m});
    bus(1'b0, a, 32'h0000_0000);
  endtask
  function automatic logic [31:0] stat(logic [3:0] v, logic r, logic rf);
    return {24'h00_0000, v[2], v[3], v[0], v[1], 1'b0, rf, rf, r};
  endfunction
  // read data is taken at the edge where the slave is ready again
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      nt = notes.pop_front();
      check(nt.name, hrdata & nt.mask, nt.val & nt.mask);
      rd_dp = 1'b0;
    end
    if (hsel && hready && htrans[1] && !hwrite) rd_dp = 1'b1;
  end
  initial begin
    seed = 50913;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, rd_dp} = '0;
    {fault_phase, fault_res, primary_trip, digital_in, block_in, fails, checks_done} = '0;
    hsize = 3'h2;
    stuck = 1'b1;
    max_phase_current = 16'h0000;
    residual_current = 16'h0000;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    rd("ctrl", OFS_CTRL, 32'h0000_0004);
    rd("retrip delay", OFS_RETRIP_DLY, 32'h0000_0014);
    rd("failure delay", OFS_CBF_DLY, 32'h0000_0028);
    rd("unmapped", 8'h24, 32'h0000_0000);
    bus(1'b1, OFS_RETRIP_DLY, 32'h0000_0001);
    bus(1'b1, OFS_CBF_DLY, 32'h0000_0002);
    bus(1'b1, OFS_EV_SEL, 32'h0000_0002);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_CTRL, 32'(c) | 32'h0000_0004);
      prev = 1'b0;
      for (int s = 0; s < 4; s++) begin
        {fault_phase, fault_res, primary_trip, digital_in} <= vec[c][s];
        run = runs[c][s];
        rd("status at change", OFS_STATUS, stat(vec[c][s], run, run & prev), 32'hff);
        repeat (60) @(posedge hclk);
        check("failure pin", {31'h0, breaker_failure_output}, {31'h0, run});
        rd("status held", OFS_STATUS, stat(vec[c][s], run, run), 32'hff);
        prev = run;
      end
      $display("criterion %0d done", c);
    end
    rd("retrip failure counts", OFS_CNT_A, 32'h0004_0004);
    rd("blocked start counts", OFS_CNT_B, 32'h0000_0004);
    rd("newest event", OFS_EV_CODE, 32'h0000_0400, 32'h1fff);
    rd("record fill", OFS_REC_IDX, 32'h0000_00c0, 32'h1ff);
    bus(1'b1, OFS_REC_IDX, 32'h0000_000a);
    rd("second oldest record", OFS_REC_INFO, 32'h0000_0001, 32'h7f);
    bus(1'b1, OFS_REC_IDX, 32'h0000_0000);
    bus(1'b1, OFS_CNT_CLR, 32'h0000_000f);
    rd("counts a cleared", OFS_CNT_A, 32'h0000_0000);
    rd("counts b cleared", OFS_CNT_B, 32'h0000_0000);
    $display("counters and logs done");
    max_phase_current <= 16'($random(seed));
    residual_current <= 16'($random(seed));
    bus(1'b1, OFS_TIME_MS, 32'h0001_0000);
    bus(1'b1, OFS_CTRL, 32'h0000_0054);
    fault_phase <= 1'b1;
    repeat (10) @(posedge hclk);
    block_in <= 1'b1;
    rd("status blocked", OFS_STATUS, 32'h0000_0008, 32'h0f);
    rd("record source", OFS_REC_INFO, 32'h0000_0053, 32'h7f);
    rd("record currents", OFS_REC_CUR, {max_phase_current, residual_current});
    rd("event stamp", OFS_EV_TS, 32'h0001_0000, 32'hffff_ff00);
    rd("record stamp", OFS_REC_TS, 32'h0001_0000, 32'hffff_ff00);
    rd("time to failure", OFS_REC_TTC, 32'h0000_000a);
    rd("time to retrip", OFS_REC_TTR, 32'h0000_0005);
    rd("blocked start counts", OFS_CNT_B, 32'h0001_0001);
    {block_in, fault_phase} <= 2'b00;
    $display("blocking done");
    bus(1'b1, OFS_CTRL, 32'h0000_0005);
    stuck <= 1'b0;
    {fault_phase, primary_trip} <= 2'b11;
    repeat (60) @(posedge hclk);
    rd("status after clearing", OFS_STATUS, 32'h0000_0010, 32'hff);
    check("upstream trip", {31'h0, upstream_open}, 32'h0000_0000);
    $display("clearing breaker done");
    summarize();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    summarize();
  end
endmodule
